// ---- core/cscpd_pkg.sv ----
package cscpd_pkg;

  // Clock rate and derived timing.
  localparam int CORE_CLK_MHZ = 250;
  localparam int PU_MAX_MS = 3;
  localparam int PU_MAX_CYC = PU_MAX_MS * 1000 * CORE_CLK_MHZ;
  localparam int PU_WAKE_CYC = PU_MAX_CYC / 2;
  localparam int POR_CYC = 64;
  localparam int CNT_W = 20;

  // Output groups and their widths.
  localparam int NGRP = 5;
  localparam int G_CPU = 0;
  localparam int G_SDR = 1;
  localparam int G_PCI = 2;
  localparam int G_REF = 3;
  localparam int G_F48 = 4;
  localparam int CPU_W = 3;
  localparam int SDR_W = 13;
  localparam int PCI_W = 6;
  localparam int STRAP_W = 5;

  // Half periods in core cycles for each group.
  localparam int HALF_W = 8;
  localparam logic [HALF_W-1:0] HALF_CPU = 8'h01;
  localparam logic [HALF_W-1:0] HALF_SDR = 8'h01;
  localparam logic [HALF_W-1:0] HALF_PCI = 8'h04;
  localparam logic [HALF_W-1:0] HALF_REF = 8'h09;
  localparam logic [HALF_W-1:0] HALF_F48 = 8'h03;

  // Register map.
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_STAT = 32'h0000_0004;
  localparam int STAT_STOP_LSB = 5;
  localparam int STAT_ST_LSB = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_RUN = 3'b001,
    ST_PDSTOP = 3'b010,
    ST_PDOFF = 3'b011,
    ST_WAKE = 3'b100
  } cscpd_state_e;

endpackage

// ---- core/cscpd_gate_if.sv ----
`timescale 1ns/1ps
interface cscpd_gate_if;
  import cscpd_pkg::*;
  logic run;
  logic osc;
  logic [HALF_W-1:0] half;
  logic clk_out;
  logic stopped;
  modport gen (input run, input osc, input half,
               output clk_out, output stopped);
  modport ctl (output run, output osc, output half,
               input clk_out, input stopped);
endinterface

// ---- core/cscpd_gate.sv ----
`timescale 1ns/1ps
module cscpd_gate (
  input wire logic clk_in,
  input wire logic rst_in,
  cscpd_gate_if.gen g
);
  import cscpd_pkg::*;

  logic [HALF_W-1:0] cnt_q;
  logic clk_q;
  logic stop_q;
  logic tick;
  logic clk_d;

  assign tick = (cnt_q == g.half - HALF_W'(1));
  // Only a low phase may be stretched, so a stop never cuts a high pulse
  // and a restart always begins with a whole high phase.
  assign clk_d = clk_q ? 1'b0 : g.run;
  assign g.clk_out = clk_q;
  assign g.stopped = stop_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
      stop_q <= 1'b1;
    end else if (g.osc && tick) begin
      cnt_q <= '0;
      clk_q <= clk_d;
      stop_q <= !clk_d && !g.run;
    end else if (g.osc) begin
      cnt_q <= cnt_q + HALF_W'(1);
    end
  end

endmodule // cscpd_gate

// ---- core/cscpd_top.sv ----
`timescale 1ns/1ps
module cscpd_top #(
  parameter int WAKE_CYCLES = cscpd_pkg::PU_WAKE_CYC
) (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Asynchronous requests from the chipset, active low.
  input wire logic CPU_STOP_N_IN,
  input wire logic PCI_STOP_N_IN,
  input wire logic SDRAM_STOP_N_IN,
  input wire logic POWER_DOWN_REQUEST_N_IN,
  // Shared strap and clock pins.
  input wire logic [cscpd_pkg::STRAP_W-1:0] STRAP_IN,
  output logic [cscpd_pkg::STRAP_W-1:0] STRAP_OUT,
  output logic [cscpd_pkg::STRAP_W-1:0] STRAP_OE_OUT,
  // Clock outputs.
  output logic [cscpd_pkg::CPU_W-1:0] CPU_CLK_OUT,
  output logic [cscpd_pkg::SDR_W-1:0] SDRAM_CLK_OUT,
  output logic [cscpd_pkg::PCI_W-1:0] PCI_GROUP_OUTPUTS_OUT,
  output logic REF_CLK_OUT,
  output logic F48_CLK_OUT,
  // Oscillator and crystal enables.
  output logic OSC_EN_OUT,
  output logic XTAL_EN_OUT,
  // AXI4-Lite slave.
  input wire logic [31:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [31:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN
);
  import cscpd_pkg::*;

  localparam int NSYNC = 4 + STRAP_W;

  function automatic logic [1:0] addr_sel(input logic [31:0] a);
    addr_sel = {a == OFS_STAT, a == OFS_CTRL};
  endfunction

  cscpd_gate_if gif [NGRP] ();

  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic cpu_stop_s;
  logic pci_stop_s;
  logic sdr_stop_s;
  logic pd_s;
  logic [STRAP_W-1:0] strap_s;
  cscpd_state_e st_q;
  cscpd_state_e st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [STRAP_W-1:0] strap_q;
  logic strap_oe_q;
  logic [NGRP-1:0] sw_stop_q;
  logic [NGRP-1:0] run;
  logic [NGRP-1:0] gclk;
  logic [NGRP-1:0] gstop;
  logic [HALF_W-1:0] half [NGRP];
  logic osc_on;
  logic all_stopped;
  logic por_done;
  logic wake_done;

  // The first synchroniser stage feeds only the second.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= {STRAP_IN, POWER_DOWN_REQUEST_N_IN, SDRAM_STOP_N_IN,
                 PCI_STOP_N_IN, CPU_STOP_N_IN};
      sync_q <= meta_q;
    end
  end

  assign cpu_stop_s = !sync_q[0];
  assign pci_stop_s = !sync_q[1];
  assign sdr_stop_s = !sync_q[2];
  assign pd_s = !sync_q[3];
  assign strap_s = sync_q[NSYNC-1:4];

  // Power sequencing.
  assign por_done = (cnt_q == CNT_W'(POR_CYC - 1));
  assign wake_done = (cnt_q == CNT_W'(WAKE_CYCLES - 1));
  assign all_stopped = &gstop;
  assign osc_on = (st_q != ST_PDOFF);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CNT_W'(1);
    unique case (st_q)
      ST_POR: begin
        if (por_done) begin
          st_d = ST_RUN;
          cnt_d = '0;
        end
      end
      ST_RUN: begin
        cnt_d = '0;
        if (pd_s) begin
          st_d = ST_PDSTOP;
        end
      end
      ST_PDSTOP: begin
        cnt_d = '0;
        if (all_stopped) begin
          st_d = ST_PDOFF;
        end
      end
      ST_PDOFF: begin
        cnt_d = '0;
        if (!pd_s) begin
          st_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (pd_s) begin
          st_d = ST_PDSTOP;
          cnt_d = '0;
        end else if (wake_done) begin
          st_d = ST_RUN;
          cnt_d = '0;
        end
      end
      default: begin
        st_d = ST_POR;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      st_q <= ST_POR;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Straps are caught by the clock at the end of power-on reset, never
  // by the reset itself, so the latch holds the pins' settled level.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      strap_q <= '0;
      strap_oe_q <= 1'b0;
    end else if (st_q == ST_POR && por_done) begin
      strap_q <= strap_s;
      strap_oe_q <= 1'b1;
    end
  end

  // Each group only sees its own halt request. Halts are dropped during
  // power-down because every group is stopped by the sequencer then.
  assign run[G_CPU] = (st_q == ST_RUN) && !cpu_stop_s
                      && !sw_stop_q[G_CPU];
  assign run[G_SDR] = (st_q == ST_RUN) && !sdr_stop_s
                      && !sw_stop_q[G_SDR];
  assign run[G_PCI] = (st_q == ST_RUN) && !pci_stop_s
                      && !sw_stop_q[G_PCI];
  assign run[G_REF] = (st_q == ST_RUN) && !sw_stop_q[G_REF];
  assign run[G_F48] = (st_q == ST_RUN) && !sw_stop_q[G_F48];

  assign half[G_CPU] = HALF_CPU;
  assign half[G_SDR] = HALF_SDR;
  assign half[G_PCI] = HALF_PCI;
  assign half[G_REF] = HALF_REF;
  assign half[G_F48] = HALF_F48;

  // With a one-cycle half period the two synchroniser stages plus the
  // gate flop keep processor start and stop latency under four cycles.
  for (genvar i = 0; i < NGRP; i++) begin : g_grp
    assign gif[i].run = run[i];
    assign gif[i].osc = osc_on;
    assign gif[i].half = half[i];
    assign gclk[i] = gif[i].clk_out;
    assign gstop[i] = gif[i].stopped;
    cscpd_gate u_gate (
      .clk_in(CORE_CLK_IN),
      .rst_in(RST_IN),
      .g(gif[i])
    );
  end

  assign CPU_CLK_OUT = {CPU_W{gclk[G_CPU]}};
  assign SDRAM_CLK_OUT = {SDR_W{gclk[G_SDR]}};
  assign PCI_GROUP_OUTPUTS_OUT = {PCI_W{gclk[G_PCI]}};
  assign REF_CLK_OUT = gclk[G_REF];
  assign F48_CLK_OUT = gclk[G_F48];

  // Strap pins carry one extra copy of each group once released.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      STRAP_OUT <= '0;
      STRAP_OE_OUT <= '0;
      OSC_EN_OUT <= 1'b1;
      XTAL_EN_OUT <= 1'b1;
    end else begin
      STRAP_OUT <= strap_oe_q ? gclk : '0;
      STRAP_OE_OUT <= {STRAP_W{strap_oe_q}};
      OSC_EN_OUT <= (st_d != ST_PDOFF);
      XTAL_EN_OUT <= (st_d != ST_PDOFF);
    end
  end

  // AXI4-Lite write path.
  logic aw_have_q;
  logic w_have_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [1:0] wsel;

  assign aw_take = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
  assign w_take = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  assign wr_go = aw_have_q && w_have_q && !S_AXI_BVALID_OUT;
  assign wsel = addr_sel(awaddr_q);

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      S_AXI_AWREADY_OUT <= 1'b1;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      awaddr_q <= S_AXI_AWADDR_IN;
      S_AXI_AWREADY_OUT <= 1'b0;
    end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
      aw_have_q <= 1'b0;
      S_AXI_AWREADY_OUT <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      S_AXI_WREADY_OUT <= 1'b1;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      wdata_q <= S_AXI_WDATA_IN;
      wstrb_q <= S_AXI_WSTRB_IN;
      S_AXI_WREADY_OUT <= 1'b0;
    end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
      w_have_q <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      sw_stop_q <= '0;
    end else if (wr_go && wsel[0] && wstrb_q[0]) begin
      sw_stop_q <= wdata_q[NGRP-1:0];
    end
  end

  // AXI4-Lite read path.
  logic [1:0] rsel;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  assign rsel = addr_sel(S_AXI_ARADDR_IN);
  assign stat_word = {19'h0, 3'(st_q), gstop, strap_q};
  assign rd_word = rsel[0] ? {27'h0, sw_stop_q} :
                   rsel[1] ? stat_word : 32'h0000_0000;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= '0;
      S_AXI_RRESP_OUT <= RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT <= rd_word;
      S_AXI_RRESP_OUT <= (|rsel) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

endmodule // cscpd_top

// ---- bench/cscpd_monitor.sv ----
`timescale 1ns/1ps
module cscpd_monitor import cscpd_pkg::*; (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // Requests.
  input wire logic CPU_STOP_N_IN,
  input wire logic POWER_DOWN_REQUEST_N_IN,
  // Pins and clocks.
  input wire logic [STRAP_W-1:0] STRAP_OUT,
  input wire logic [STRAP_W-1:0] STRAP_OE_OUT,
  input wire logic [CPU_W-1:0] CPU_CLK_OUT,
  input wire logic [SDR_W-1:0] SDRAM_CLK_OUT,
  input wire logic [PCI_W-1:0] PCI_GROUP_OUTPUTS_OUT,
  input wire logic REF_CLK_OUT,
  input wire logic F48_CLK_OUT,
  input wire logic OSC_EN_OUT,
  // Read channel.
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN
);
  logic [5:0] pd_cnt_q;
  logic [5:0] pd_cnt_d;
  wire [4:0] grp = {F48_CLK_OUT, REF_CLK_OUT, PCI_GROUP_OUTPUTS_OUT[0],
                    SDRAM_CLK_OUT[0], CPU_CLK_OUT[0]};
  wire any_clk = |{CPU_CLK_OUT, SDRAM_CLK_OUT, PCI_GROUP_OUTPUTS_OUT,
                   REF_CLK_OUT, F48_CLK_OUT};
  // The slow reference group may need a whole high phase to park.
  assign pd_cnt_d = POWER_DOWN_REQUEST_N_IN ? 6'h0 :
                    (pd_cnt_q == 6'h3F) ? pd_cnt_q : pd_cnt_q + 6'h1;
  always_ff @(posedge CORE_CLK_IN) begin
    pd_cnt_q <= RST_IN ? 6'h0 : pd_cnt_d;
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  a_cpu_stop_lat: assert property (
    !CPU_STOP_N_IN [*4] |=> CPU_CLK_OUT == 3'h0)
    else $error("cpu clocks run after halt");
  a_pd_cpu_fast: assert property (
    !POWER_DOWN_REQUEST_N_IN [*5] |=> CPU_CLK_OUT == 3'h0)
    else $error("cpu clocks run in power down");
  a_pd_all_low: assert property (
    pd_cnt_q >= 6'h28 |-> !any_clk)
    else $error("clock output not parked in power down");
  a_osc_off_low: assert property (
    !OSC_EN_OUT |-> !any_clk)
    else $error("oscillator off with clock running");
  a_pci_high_full: assert property (
    $rose(PCI_GROUP_OUTPUTS_OUT[0]) |=> PCI_GROUP_OUTPUTS_OUT[0] [*3])
    else $error("short pci high phase");
  a_pci_low_park: assert property (
    $fell(PCI_GROUP_OUTPUTS_OUT[0]) |-> !PCI_GROUP_OUTPUTS_OUT[0] [*4])
    else $error("short pci low phase");
  a_strap_copy: assert property (
    &STRAP_OE_OUT |-> STRAP_OUT == $past(grp))
    else $error("strap pin not driving its clock");
  a_osc_wake: assert property (
    $rose(OSC_EN_OUT) |-> $past(POWER_DOWN_REQUEST_N_IN, 3))
    else $error("oscillator woke without release");
  a_rdata_hold: assert property (
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
      |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read answer dropped or changed");
endmodule // cscpd_monitor

bind cscpd_top cscpd_monitor cscpd_monitor_i (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
  .CPU_STOP_N_IN(CPU_STOP_N_IN),
  .POWER_DOWN_REQUEST_N_IN(POWER_DOWN_REQUEST_N_IN),
  .STRAP_OUT(STRAP_OUT), .STRAP_OE_OUT(STRAP_OE_OUT),
  .CPU_CLK_OUT(CPU_CLK_OUT), .SDRAM_CLK_OUT(SDRAM_CLK_OUT),
  .PCI_GROUP_OUTPUTS_OUT(PCI_GROUP_OUTPUTS_OUT),
  .REF_CLK_OUT(REF_CLK_OUT), .F48_CLK_OUT(F48_CLK_OUT),
  .OSC_EN_OUT(OSC_EN_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN));

// ---- bench/cscpd_chipset.sv ----
`timescale 1ns/1ps
module cscpd_chipset (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Commands: bit 0 processor, 1 pci, 2 sdram.
  input wire logic [2:0] halt_in,
  input wire logic pd_in,
  // Request lines, active low.
  output logic [2:0] stop_n_out,
  output logic pd_n_out
);
  int rel[3];
  // A halt waits until the line has been released long enough. Spacing
  // is counted in core cycles: a processor clock lasts two of them and
  // a PCI clock eight.
  always_ff @(posedge clk_in) begin
    pd_n_out <= rst_in | !pd_in;
    for (int i = 0; i < 3; i++) begin
      rel[i] <= (rst_in || !stop_n_out[i]) ? 0 : rel[i] + 1;
      if (rst_in || !halt_in[i]) begin
        stop_n_out[i] <= 1'h1;
      end else if (rel[i] >= (i == 0 ? 200 : 80)) begin
        stop_n_out[i] <= 1'h0;
      end
    end
  end
endmodule // cscpd_chipset

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import cscpd_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] halt = 3'h0;
  logic pd = 1'h0;
  logic [4:0] strap = 5'h0;
  logic [2:0] stop_n;
  logic pd_n;
  logic [4:0] s_o, s_oe, pin, p, c;
  logic [2:0] cpu;
  logic [12:0] sdr;
  logic [5:0] pci;
  logic rf, f48, osc, xt, awr, wrd, bv, arr, rv;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdat, v;
  logic awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
  logic [1:0] bresp, rresp, r;
  int failures = 0, samples_checked = 0, cyc = 0, ctl, g, e[5];
  int m_ctrl = 0;
  logic [3:0] ws = 4'hF;
  assign pin = (s_oe & s_o) | (~s_oe & strap);
  assign c = {f48, rf, pci[0], sdr[0], cpu[0]};
  cscpd_chipset cscpd_chipset_i (.clk_in(clk), .rst_in(rst),
    .halt_in(halt), .pd_in(pd), .stop_n_out(stop_n), .pd_n_out(pd_n));
  cscpd_top #(.WAKE_CYCLES(20)) cscpd_top_i (.CORE_CLK_IN(clk),
    .RST_IN(rst), .CPU_STOP_N_IN(stop_n[0]), .PCI_STOP_N_IN(stop_n[1]),
    .SDRAM_STOP_N_IN(stop_n[2]), .POWER_DOWN_REQUEST_N_IN(pd_n),
    .STRAP_IN(pin), .STRAP_OUT(s_o), .STRAP_OE_OUT(s_oe),
    .CPU_CLK_OUT(cpu), .SDRAM_CLK_OUT(sdr), .PCI_GROUP_OUTPUTS_OUT(pci),
    .REF_CLK_OUT(rf), .F48_CLK_OUT(f48), .OSC_EN_OUT(osc),
    .XTAL_EN_OUT(xt), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(brd), .S_AXI_ARADDR_IN(ara),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rrd));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic summarize;
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, x);
    samples_checked++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  // Each side is sampled a step after the edge, so readies seen are
  // the values that the following edge will take.
  task automatic wr(input logic [31:0] a, d);
    logic ha, hw, hb;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; brd <= 1'h1;
    forever begin
      #1; ha = awv & awr; hw = wv & wrd; hb = brd & bv; r = bresp;
      @(posedge clk);
      if (ha) awv <= 1'h0;
      if (hw) wv <= 1'h0;
      if (hb) begin
        brd <= 1'h0;
        break;
      end
    end
    chk("bresp", r, (a == OFS_CTRL || a == OFS_STAT) ? RESP_OKAY
        : RESP_SLVERR);
    if (a == OFS_CTRL && ws[0]) m_ctrl = d & 32'h1F;
  endtask
  // Read ready is at times held back after the answer shows, so that
  // the slave must keep its read data standing until it is taken.
  task automatic rd(input logic [31:0] a);
    logic ha, hb, hv;
    int w;
    w = $urandom_range(2);
    @(posedge clk);
    ara <= a; arv <= 1'h1; rrd <= (w == 0);
    forever begin
      #1; ha = arv & arr; hb = rrd & rv; hv = rv; v = rdat; r = rresp;
      @(posedge clk);
      if (ha) arv <= 1'h0;
      if (hb) begin
        rrd <= 1'h0;
        break;
      end
      if (hv && !rrd) begin
        w--;
        if (w == 0) rrd <= 1'h1;
      end
    end
    chk("rresp", r, (a == OFS_CTRL || a == OFS_STAT) ? RESP_OKAY
        : RESP_SLVERR);
    if (a == OFS_CTRL) chk("ctrl model", v, m_ctrl);
  endtask
  task automatic tg(input int n);
    foreach (e[i]) e[i] = 0;
    p = 5'h1F;
    repeat (n) begin
      #1;
      foreach (e[i]) if (c[i] && !p[i]) e[i]++;
      p = c;
      @(posedge clk);
    end
  endtask
  initial begin
    void'($urandom(35511));
    strap = 5'($urandom());
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (80) @(posedge clk);
    chk("strap oe", s_oe, 32'h1F);
    rd(OFS_STAT);
    chk("stat", v, {19'h0, 3'h1, 5'h0, strap});
    rd(32'h10);
    chk("bad rd", {r, v[29:0]}, {RESP_SLVERR, 30'h0});
    wr(32'h10, 32'hFFFF_FFFF);
    chk("bad wr", r, RESP_SLVERR);
    ctl = $urandom_range(31);
    wr(OFS_CTRL, ctl);
    rd(OFS_CTRL);
    chk("ctrl", v, ctl);
    ws <= 4'hE;
    wr(OFS_CTRL, 32'h0);
    ws <= 4'hF;
    rd(OFS_CTRL);
    chk("strobe", v, ctl);
    repeat (40) @(posedge clk);
    rd(OFS_STAT);
    chk("stop flags", v, {19'h0, 3'h1, 5'(ctl), strap});
    tg(40);
    for (int i = 0; i < 5; i++) chk("sw halt", e[i] == 0, ctl[i]);
    wr(OFS_CTRL, 32'h0);
    for (int j = 0; j < 3; j++) begin
      g = (j == 0) ? 0 : 3 - j;
      halt[j] <= 1'h1;
      repeat (150) @(posedge clk);
      tg(24);
      for (int i = 0; i < 5; i++) chk("halt", e[i] > 0, i != g);
      halt[j] <= 1'h0;
      tg(g == 0 ? 7 : 20);
      chk("restart", e[g] > 0, 1);
    end
    pd <= 1'h1;
    repeat (60) @(posedge clk);
    chk("osc off", {osc, xt}, 2'h0);
    halt <= 3'h3;
    tg(20);
    for (int i = 0; i < 5; i++) chk("pd idle", e[i], 0);
    rd(OFS_STAT);
    chk("pd stat", v, {19'h0, 3'h3, 5'h1F, strap});
    halt <= 3'h0;
    pd <= 1'h0;
    repeat (60) @(posedge clk);
    chk("osc on", {osc, xt}, 2'h3);
    tg(24);
    for (int i = 0; i < 5; i++) chk("wake", e[i] > 0, 1);
    summarize();
  end
endmodule // tb_top
